// file: include/tic_pkg.sv
// Package holding register addresses, control field positions and timing constants.
// Assumes a core-side special-function-register port at 10 MHz.
package tic_pkg;
    localparam logic [7:0] CTRL_ADDR     = 8'hA1;
    localparam logic [7:0] FRAC_ADDR     = 8'hA2;
    localparam logic [7:0] SEC_ADDR      = 8'hA3;
    localparam logic [7:0] MIN_ADDR      = 8'hA4;
    localparam logic [7:0] HOUR_ADDR     = 8'hA5;
    localparam logic [7:0] TARGET_ADDR   = 8'hA6;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CTRL_WMASK    = 8'h7F;
    localparam int         WRAP_BIT      = 6;
    localparam int         TBASE_HI_BIT  = 5;
    localparam int         TBASE_LO_BIT  = 4;
    localparam int         ONESHOT_BIT   = 3;
    localparam int         MATCH_BIT     = 2;
    localparam int         ICNT_ON_BIT   = 1;
    localparam int         GATE_BIT      = 0;
    localparam logic [7:0] FRAC_MAX      = 8'h7F;
    localparam logic [7:0] SEC_MAX       = 8'h3B;
    localparam logic [7:0] HOUR_DAY_MAX  = 8'h17;
    localparam logic [7:0] HOUR_FULL_MAX = 8'hFF;
    localparam int         CLK_HZ        = 10000000;
    localparam int         XTAL_HZ       = 32768;
    localparam int         XTAL_SYNC_CYC = 2;
    localparam logic [15:0] VECTOR_ADDR  = 16'h0053;
endpackage : tic_pkg

// file: logic/tick_divider.sv
// Produces a one-cycle pulse every 1/128 second from the synchronised crystal clock level.
// Assumes xtalClk is synchronous to clk (already a clean level at 32.768 kHz).
`timescale 1ns/1ps
module tick_divider (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Crystal and gate
    input  wire logic xtalClk,
    input  wire logic gateOn,
    // Tick out
    output logic      tick128
);
    logic       xtalSync_reg;
    logic       xtalLast_reg;
    logic [7:0] div_reg;
    logic       xtalEdge;

    assign xtalEdge = xtalSync_reg & ~xtalLast_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xtalSync_reg <= 1'b0;
            xtalLast_reg <= 1'b0;
        end else begin
            xtalSync_reg <= xtalClk;
            xtalLast_reg <= xtalSync_reg;
        end
    end

    // The crystal is divided by 256 into the 1/128-second step while the gate is on.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 8'h00;
            tick128 <= 1'b0;
        end else begin
            tick128 <= 1'b0;
            if (!gateOn) begin
                div_reg <= 8'h00;
            end else if (xtalEdge) begin
                div_reg <= div_reg + 8'h01;
                tick128 <= (div_reg == 8'hFF);
            end
        end
    end
endmodule : tick_divider

// file: logic/time_interval_counter.sv
// Time interval counter with real-time clock registers on the core register port.
// Assumes single-cycle register strobes synchronous to clk and a 32.768 kHz crystal level.
//
// Summary of operation
// R1: Counting is timed from the 32.768 kHz crystal and continues during power-down.
// R2: Register accesses finish at crystal rate; software waits for busy to clear.
// R3: Intervals from 1/128 second up to 255 hours are supported.
// R4: The interval counter advances on each rollover of the selected time register.
// R5: Counter equal to target sets the match flag, bit 2, and interrupts if enabled.
// R6: In power-down an enabled match wakes the core toward the counter vector.
// R7: Control bit 7 is unimplemented; writes to it are ignored.
// R8: Wrap select set makes hours count 0 to 23, otherwise 0 to 255.
// R9: Bits 5:4 select timebase: 1/128 second, seconds, minutes or hours.
// R10: With one-shot set, a timeout clears the interval count enable.
// R11: With one-shot clear, the interval counter reloads on each timeout.
// R12: The match flag stays set until software clears it.
// R13: Bit 1 enables the interval counter; clearing it disables that counter.
// R14: Bit 0 passes the crystal-derived clock to the time and interval counters.
// R15: Clearing bit 0 stops counting and restores time registers to last writes.
// R16: Time registers take software writes while the clock gate is low.
// R17: The fraction counts 0 to 127 each 1/128 second, carrying into seconds.
// R18: Seconds and minutes count 0 to 59, carrying into the next register.
// R19: The interval counter starts from zero on enable and on each reload.
`timescale 1ns/1ps
module time_interval_counter (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Crystal, power state and interrupt enable
    input  wire logic        xtalClk,
    input  wire logic        powerDown,
    input  wire logic        intEnable,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    output logic             regBusy,
    // Events to the core
    output logic             matchIrq,
    output logic             wakeReq,
    output logic      [15:0] wakeVector
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_reg;
    logic [7:0] frac_reg;
    logic [7:0] sec_reg;
    logic [7:0] min_reg;
    logic [7:0] hour_reg;
    logic [7:0] fracSaved_reg;
    logic [7:0] secSaved_reg;
    logic [7:0] minSaved_reg;
    logic [7:0] hourSaved_reg;
    logic [7:0] target_reg;
    logic [7:0] icnt_reg;
    logic       xsA_reg;
    logic       xsB_reg;
    logic       xsC_reg;
    logic       pendWr_reg;
    logic       pendRd_reg;
    logic [7:0] pendAddr_reg;
    logic [7:0] pendData_reg;
    logic       tick128;
    logic       xEdge;
    logic       fracRoll;
    logic       secRoll;
    logic       minRoll;
    logic       hourRoll;
    logic       baseRoll;
    logic       matchNow;
    logic [7:0] hourMax;
    logic       gateOn;
    logic       icntOn;

    assign gateOn  = ctrl_reg[tic_pkg::GATE_BIT];
    assign icntOn  = ctrl_reg[tic_pkg::ICNT_ON_BIT];
    assign hourMax = ctrl_reg[tic_pkg::WRAP_BIT] ? tic_pkg::HOUR_DAY_MAX
                                                 : tic_pkg::HOUR_FULL_MAX; // R8

    tick_divider divider (
        .clk     (clk),
        .rstn    (rstn),
        .xtalClk (xtalClk),
        .gateOn  (gateOn),
        .tick128 (tick128)
    ); // R1 R14

    ////////////////////////////////////////////////////////////////////////////////
    // Register accesses wait for a crystal edge before taking effect.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xsA_reg <= 1'b0;
            xsB_reg <= 1'b0;
            xsC_reg <= 1'b0;
        end else begin
            xsA_reg <= xtalClk;
            xsB_reg <= xsA_reg;
            xsC_reg <= xsB_reg;
        end
    end
    assign xEdge = xsB_reg & ~xsC_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pendWr_reg   <= 1'b0;
            pendRd_reg   <= 1'b0;
            pendAddr_reg <= 8'h00;
            pendData_reg <= 8'h00;
            regBusy      <= 1'b0;
        end else if (!regBusy && (regWrite || regRead)) begin
            pendWr_reg   <= regWrite;
            pendRd_reg   <= regRead & ~regWrite;
            pendAddr_reg <= regAddr;
            pendData_reg <= regWdata;
            regBusy      <= 1'b1; // R2
        end else if (regBusy && xEdge) begin
            pendWr_reg <= 1'b0;
            pendRd_reg <= 1'b0;
            regBusy    <= 1'b0; // R2
        end
    end

    logic doWr;
    logic doRd;
    assign doWr = regBusy & xEdge & pendWr_reg;
    assign doRd = regBusy & xEdge & pendRd_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (doRd) begin
            unique case (pendAddr_reg)
                tic_pkg::CTRL_ADDR:   regRdata <= ctrl_reg & tic_pkg::CTRL_WMASK; // R7
                tic_pkg::FRAC_ADDR:   regRdata <= frac_reg;
                tic_pkg::SEC_ADDR:    regRdata <= sec_reg;
                tic_pkg::MIN_ADDR:    regRdata <= min_reg;
                tic_pkg::HOUR_ADDR:   regRdata <= hour_reg;
                tic_pkg::TARGET_ADDR: regRdata <= target_reg;
                default:              regRdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time chain.
    assign fracRoll = gateOn & tick128 & (frac_reg == tic_pkg::FRAC_MAX); // R17
    assign secRoll  = fracRoll & (sec_reg == tic_pkg::SEC_MAX);          // R18
    assign minRoll  = secRoll & (min_reg == tic_pkg::SEC_MAX);           // R18
    assign hourRoll = minRoll & (hour_reg == hourMax);                   // R8

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frac_reg      <= 8'h00;
            sec_reg       <= 8'h00;
            min_reg       <= 8'h00;
            hour_reg      <= 8'h00;
            fracSaved_reg <= 8'h00;
            secSaved_reg  <= 8'h00;
            minSaved_reg  <= 8'h00;
            hourSaved_reg <= 8'h00;
        end else if (doWr && !gateOn && pendAddr_reg == tic_pkg::FRAC_ADDR) begin
            frac_reg      <= pendData_reg; // R16
            fracSaved_reg <= pendData_reg;
        end else if (doWr && !gateOn && pendAddr_reg == tic_pkg::SEC_ADDR) begin
            sec_reg      <= pendData_reg; // R16
            secSaved_reg <= pendData_reg;
        end else if (doWr && !gateOn && pendAddr_reg == tic_pkg::MIN_ADDR) begin
            min_reg      <= pendData_reg; // R16
            minSaved_reg <= pendData_reg;
        end else if (doWr && !gateOn && pendAddr_reg == tic_pkg::HOUR_ADDR) begin
            hour_reg      <= pendData_reg; // R16
            hourSaved_reg <= pendData_reg;
        end else if (!gateOn) begin
            frac_reg <= fracSaved_reg; // R15
            sec_reg  <= secSaved_reg;
            min_reg  <= minSaved_reg;
            hour_reg <= hourSaved_reg;
        end else if (tick128) begin
            frac_reg <= fracRoll ? 8'h00 : frac_reg + 8'h01; // R17
            if (fracRoll) begin
                sec_reg <= secRoll ? 8'h00 : sec_reg + 8'h01; // R18
            end
            if (secRoll) begin
                min_reg <= minRoll ? 8'h00 : min_reg + 8'h01; // R18
            end
            if (minRoll) begin
                hour_reg <= hourRoll ? 8'h00 : hour_reg + 8'h01; // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interval counter and match.
    always_comb begin
        unique case (ctrl_reg[tic_pkg::TBASE_HI_BIT:tic_pkg::TBASE_LO_BIT])
            2'b00: baseRoll = gateOn & tick128; // R9 R3
            2'b01: baseRoll = fracRoll;         // R9
            2'b10: baseRoll = secRoll;          // R9
            2'b11: baseRoll = minRoll;          // R9
        endcase
    end

    assign matchNow = icntOn & baseRoll & ((icnt_reg + 8'h01) == target_reg); // R5

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            icnt_reg <= 8'h00;
        end else if (!icntOn || matchNow) begin
            icnt_reg <= 8'h00; // R19 R11 R13
        end else if (baseRoll) begin
            icnt_reg <= icnt_reg + 8'h01; // R4
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            target_reg <= 8'h00;
        end else if (doWr && pendAddr_reg == tic_pkg::TARGET_ADDR) begin
            target_reg <= pendData_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= tic_pkg::CTRL_RESET;
        end else begin
            if (doWr && pendAddr_reg == tic_pkg::CTRL_ADDR) begin
                ctrl_reg <= pendData_reg & tic_pkg::CTRL_WMASK; // R7
            end
            if (matchNow) begin
                ctrl_reg[tic_pkg::MATCH_BIT] <= 1'b1; // R5 R12
                if (ctrl_reg[tic_pkg::ONESHOT_BIT]) begin
                    ctrl_reg[tic_pkg::ICNT_ON_BIT] <= 1'b0; // R10
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            matchIrq   <= 1'b0;
            wakeReq    <= 1'b0;
            wakeVector <= 16'h0000;
        end else begin
            matchIrq   <= ctrl_reg[tic_pkg::MATCH_BIT] & intEnable; // R5
            wakeReq    <= ctrl_reg[tic_pkg::MATCH_BIT] & intEnable & powerDown; // R6
            wakeVector <= tic_pkg::VECTOR_ADDR; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    bit7_zero_a: assert property (@(posedge clk) disable iff (!rstn) // R7
        ctrl_reg[7] == 1'b0) else $error("control bit 7 set");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rstn) // R12
        $fell(ctrl_reg[tic_pkg::MATCH_BIT]) |-> $past(doWr))
        else $error("match flag cleared without write");
    match_sets_a: assert property (@(posedge clk) disable iff (!rstn) // R5
        matchNow |=> ctrl_reg[tic_pkg::MATCH_BIT]) else $error("match missed");
    oneshot_stop_a: assert property (@(posedge clk) disable iff (!rstn) // R10
        matchNow && ctrl_reg[tic_pkg::ONESHOT_BIT] && !doWr |=> !icntOn)
        else $error("one-shot kept running");
    reload_zero_a: assert property (@(posedge clk) disable iff (!rstn) // R19
        matchNow |=> icnt_reg == 8'h00) else $error("no reload");
    frac_range_a: assert property (@(posedge clk) disable iff (!rstn) // R17
        gateOn && tick128 && frac_reg == tic_pkg::FRAC_MAX |=> frac_reg == 8'h00)
        else $error("fraction did not wrap");
    hour_day_a: assert property (@(posedge clk) disable iff (!rstn) // R8
        hourRoll && ctrl_reg[tic_pkg::WRAP_BIT] |=> hour_reg == 8'h00)
        else $error("hour wrap wrong");
    gate_restore_a: assert property (@(posedge clk) disable iff (!rstn) // R15
        !gateOn && !doWr |=> sec_reg == $past(secSaved_reg))
        else $error("time not restored");
    busy_ends_a: assert property (@(posedge clk) disable iff (!rstn) // R2
        $rose(regBusy) |-> ##[1:800] !regBusy) else $error("access stuck");
    wake_irq_a: assert property (@(posedge clk) disable iff (!rstn) // R6
        wakeReq |-> matchIrq && wakeVector == tic_pkg::VECTOR_ADDR)
        else $error("wake without irq");

    ////////////////////////////////////////////////////////////////////////////////
    // Access, counting and output checks.
    busy_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R2
        regBusy && !xEdge |=> regBusy)
        else $error("access ended off a crystal edge");
    busy_takes_a: assert property (@(posedge clk) disable iff (!rstn) // R2
        !regBusy && (regWrite || regRead) |=> regBusy)
        else $error("request not taken");
    saved_frozen_a: assert property (@(posedge clk) disable iff (!rstn) // R16
        gateOn |=> fracSaved_reg == $past(fracSaved_reg) && secSaved_reg == $past(secSaved_reg))
        else $error("time written while clock gate on");
    count_idle_a: assert property (@(posedge clk) disable iff (!rstn) // R13
        !icntOn |=> icnt_reg == 8'h00)
        else $error("interval counter ran while disabled");
    count_step_a: assert property (@(posedge clk) disable iff (!rstn) // R4
        icntOn && baseRoll && !matchNow |=> icnt_reg == $past(icnt_reg) + 8'h01)
        else $error("interval counter missed a rollover");
    irq_follow_a: assert property (@(posedge clk) disable iff (!rstn) // R5
        ctrl_reg[tic_pkg::MATCH_BIT] && intEnable |=> matchIrq)
        else $error("enabled flag gave no interrupt");
    hour_step_a: assert property (@(posedge clk) disable iff (!rstn) // R8
        minRoll && !hourRoll |=> hour_reg == $past(hour_reg) + 8'h01)
        else $error("hour did not advance");
    frac_step_a: assert property (@(posedge clk) disable iff (!rstn) // R17
        gateOn && tick128 && frac_reg != tic_pkg::FRAC_MAX |=> frac_reg == $past(frac_reg) + 8'h01)
        else $error("fraction did not advance");
    sec_carry_a: assert property (@(posedge clk) disable iff (!rstn) // R18
        fracRoll && !secRoll |=> sec_reg == $past(sec_reg) + 8'h01)
        else $error("seconds did not take the carry");
endmodule : time_interval_counter

// file: tb/tb_top.sv
// Self-checking bench for the time interval counter: register port, time chain and matches.
// Assumes the crystal level is made here fast, one period every 8 core cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int DLY  = 5;
    localparam int TICK = 2048;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic        xtalClk   = 1'b0;
    logic        powerDown = 1'b0;
    logic        intEnable = 1'b1;
    logic [7:0]  regAddr   = 8'h00;
    logic [7:0]  regWdata  = 8'h00;
    logic        regWrite  = 1'b0;
    logic        regRead   = 1'b0;
    logic [7:0]  regRdata;
    logic        regBusy;
    logic        matchIrq;
    logic        wakeReq;
    logic [15:0] wakeVector;
    int          errors      = 0;
    int          comparisons = 0;
    int          n;
    row_s        rows [9]  = '{'{8'hA1, 8'h80, 8'h00}, '{8'hA1, 8'hF8, 8'h78},
                               '{8'hA2, 8'h7F, 8'h7F}, '{8'hA3, 8'h3B, 8'h3B},
                               '{8'hA4, 8'h3B, 8'h3B}, '{8'hA5, 8'h17, 8'h17},
                               '{8'hA6, 8'hFF, 8'hFF}, '{8'hA7, 8'h55, 8'h00},
                               '{8'hA1, 8'h00, 8'h00}};
    row_s        bases [4] = '{'{8'h0B, 8'h00, 8'h00}, '{8'h1B, 8'h00, 8'h00},
                               '{8'h2B, 8'h3B, 8'h00}, '{8'h3B, 8'h3B, 8'h3B}};

    time_interval_counter u_dut (
        .clk(clk), .rstn(rstn), .xtalClk(xtalClk), .powerDown(powerDown),
        .intEnable(intEnable), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .regBusy(regBusy),
        .matchIrq(matchIrq), .wakeReq(wakeReq), .wakeVector(wakeVector)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #DLY xtalClk = ~xtalClk;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #DLY;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic waitBusy();
        int k;
        k = 0;
        while (regBusy !== 1'b0 && k < 400) begin
            step(1);
            k++;
        end
        if (k == 400) errors++;
    endtask : waitBusy

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        regAddr  = a;
        regWdata = d;
        regWrite = w;
        regRead  = !w;
        step(1);
        regWrite = 1'b0;
        regRead  = 1'b0;
        waitBusy();
    endtask : acc

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({8'h00, regRdata}, {8'h00, e});
    endtask : rd

    task automatic waitIrq(input int lim);
        n = 0;
        while (matchIrq !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask : waitIrq

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        step(16);
        rstn = 1'b1;
        for (int i = 0; i < 6; i++) rd(8'hA1 + 8'(i), 8'h00);
        foreach (rows[i]) begin
            acc(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // A second write while busy is ignored.
        regAddr  = tic_pkg::TARGET_ADDR;
        regWdata = 8'h11;
        regWrite = 1'b1;
        step(1);
        regWdata = 8'h22;
        step(1);
        regWrite = 1'b0;
        waitBusy();
        rd(tic_pkg::TARGET_ADDR, 8'h11);
        // Each timebase code with the fraction, and above it only its own chain, primed to roll on the next tick.
        foreach (bases[i]) begin
            acc(1'b1, tic_pkg::CTRL_ADDR, 8'h00);
            acc(1'b1, tic_pkg::FRAC_ADDR, 8'h7F);
            acc(1'b1, tic_pkg::SEC_ADDR, bases[i].d);
            acc(1'b1, tic_pkg::MIN_ADDR, bases[i].e);
            acc(1'b1, tic_pkg::TARGET_ADDR, 8'h01);
            acc(1'b1, tic_pkg::CTRL_ADDR, bases[i].a);
            waitIrq(TICK + 200);
            chk({15'h0, matchIrq}, 16'h0001);
            rd(tic_pkg::CTRL_ADDR, bases[i].a ^ 8'h06);
        end
        // Full chain rollover, restore on gate clear, both hour ranges.
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h00);
        acc(1'b1, tic_pkg::HOUR_ADDR, 8'h17);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h41);
        step(TICK + 100);
        rd(tic_pkg::HOUR_ADDR, 8'h00);
        rd(tic_pkg::MIN_ADDR, 8'h00);
        rd(tic_pkg::SEC_ADDR, 8'h00);
        acc(1'b1, tic_pkg::SEC_ADDR, 8'h05);
        rd(tic_pkg::SEC_ADDR, 8'h00);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h00);
        rd(tic_pkg::HOUR_ADDR, 8'h17);
        rd(tic_pkg::SEC_ADDR, 8'h3B);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h01);
        step(TICK + 100);
        rd(tic_pkg::HOUR_ADDR, 8'h18);
        // Repeating intervals, wake-up and the sticky flag.
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h00);
        acc(1'b1, tic_pkg::TARGET_ADDR, 8'h02);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h03);
        waitIrq(3 * TICK);
        chk({15'h0, matchIrq}, 16'h0001);
        powerDown = 1'b1;
        step(2);
        chk({15'h0, wakeReq}, 16'h0001);
        chk(wakeVector, tic_pkg::VECTOR_ADDR);
        intEnable = 1'b0;
        step(2);
        chk({15'h0, matchIrq}, 16'h0000);
        chk({15'h0, wakeReq}, 16'h0000);
        intEnable = 1'b1;
        powerDown = 1'b0;
        rd(tic_pkg::CTRL_ADDR, 8'h07);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h03);
        step(2);
        chk({15'h0, matchIrq}, 16'h0000);
        waitIrq(2 * TICK + 200);
        chk({15'h0, matchIrq}, 16'h0001);
        chk({15'h0, n > TICK}, 16'h0001);
        acc(1'b1, tic_pkg::CTRL_ADDR, 8'h01);
        step(3 * TICK);
        chk({15'h0, matchIrq}, 16'h0000);
        // Reset in mid-run, with the time clock on and a read in flight.
        regAddr = tic_pkg::HOUR_ADDR;
        regRead = 1'b1;
        step(1);
        regRead = 1'b0;
        rstn    = 1'b0;
        step(2);
        chk({regRdata, 7'h00, regBusy}, 16'h0000);
        chk({14'h0000, matchIrq, wakeReq}, 16'h0000);
        chk(wakeVector, 16'h0000);
        rstn = 1'b1;
        step(1);
        chk(wakeVector, tic_pkg::VECTOR_ADDR);
        rd(tic_pkg::CTRL_ADDR, tic_pkg::CTRL_RESET);
        step(TICK + 100);
        rd(tic_pkg::FRAC_ADDR, 8'h00);
        conclude();
    end

    initial begin
        step(90000);
        errors++;
        conclude();
    end
endmodule : tb_top
